// [csf_pkg.sv]
package csf_pkg;
  localparam logic [11:0] CSF_STATUS_IDX = 12'h0d5;
  localparam logic [11:0] CSF_STATUS_ADDR = CSF_STATUS_IDX << 2;
  localparam logic [11:0] CSF_SYM_ADDR = 12'h400;
  localparam logic [11:0] CSF_IDX_ADDR = 12'h404;
  localparam logic [11:0] CSF_EA_ADDR = 12'h408;
  localparam int CSF_BANK_BIT = 0;
  localparam int CSF_FAST_BIT = 1;
  localparam int CSF_HALF_BIT = 2;
  localparam int CSF_DKIND_BIT = 3;
  localparam logic [7:0] CSF_STATUS_RESET = 8'h00;
  localparam logic [1:0] CSF_RESP_OKAY = 2'h0;
  localparam logic [1:0] CSF_RESP_SLVERR = 2'h2;
  localparam logic [3:0] CSF_BCD_LO = 4'h9;
  localparam logic [7:0] CSF_BCD_HI = 8'h99;
  localparam logic [7:0] CSF_ADJ_LO = 8'h06;
  localparam logic [7:0] CSF_ADJ_HI = 8'h60;

  typedef enum logic [2:0]
  {
    CSF_OP_NONE = 3'b000,
    CSF_OP_ADD = 3'b001,
    CSF_OP_SUB = 3'b010,
    CSF_OP_DA = 3'b011,
    CSF_OP_SB0 = 3'b100,
    CSF_OP_SB1 = 3'b101,
    CSF_OP_FAST_INT = 3'b110,
    CSF_OP_INTERRUPT_RETURN_INSTRUCTION = 3'b111
  } csf_op_type;

  typedef enum logic [2:0]
  {
    CSF_MODE_REG_BIT = 3'b000,
    CSF_MODE_WORK_LSB = 3'b001,
    CSF_MODE_REG_PAIR = 3'b010,
    CSF_MODE_RELATIVE = 3'b011,
    CSF_MODE_SHORT_IDX = 3'b100,
    CSF_MODE_LONG_IDX = 3'b101,
    CSF_MODE_LONG_IMM = 3'b110
  } csf_mode_type;

  typedef struct packed
  {
    logic valid;
    csf_op_type op;
    logic [7:0] a;
    logic [7:0] b;
  } csf_exec_type;

  typedef struct packed
  {
    logic [7:0] result;
    logic carry;
  } csf_alu_type;
endpackage : csf_pkg

// [csf_operand_check.sv]
`timescale 1ns/1ns
module csf_operand_check
  import csf_pkg::*;
(
  input wire csf_mode_type mode,
  input wire logic [7:0] reg_num,
  input wire logic working,
  input wire logic [2:0] bit_idx,
  input wire logic [15:0] base,
  input wire logic [15:0] field,
  output logic legal,
  output logic [15:0] target
);
  wire pair_even = ~reg_num[0];
  wire work_ok = reg_num[7:4] == 4'h0;
  wire [15:0] sext = {{8{field[7]}}, field[7:0]};
  always_comb
  begin
    legal = 1'b0;
    target = 16'h0000;
    case (mode)
      // any reg or working, bit 0-7
      CSF_MODE_REG_BIT:
      begin
        legal = working ? work_ok : 1'b1;
        target = {5'h0, reg_num, bit_idx};
      end
      CSF_MODE_WORK_LSB:
      begin
        legal = work_ok;
        target = {8'h00, reg_num};
      end
      CSF_MODE_REG_PAIR:
      begin
        legal = pair_even & (working ? work_ok : 1'b1);
        target = {8'h00, reg_num};
      end
      CSF_MODE_RELATIVE:
      begin
        legal = 1'b1;
        target = base + sext;
      end
      CSF_MODE_SHORT_IDX:
      begin
        legal = pair_even & work_ok;
        target = base + sext;
      end
      CSF_MODE_LONG_IDX:
      begin
        legal = pair_even & work_ok;
        target = base + field;
      end
      CSF_MODE_LONG_IMM:
      begin
        legal = 1'b1;
        target = field;
      end
      default:
      begin
        legal = 1'b0;
        target = 16'h0000;
      end
    endcase
  end
endmodule : csf_operand_check

// [csf_status_flags.sv]
`timescale 1ns/1ns
module csf_status_flags
  import csf_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire csf_exec_type exec,
  input wire logic int_request,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output csf_alu_type alu_out,
  output logic bank_sel,
  output logic int_accept,
  output logic fast_return,
  output logic normal_return,
  output logic operand_legal,
  output logic [15:0] operand_target
);
  logic [7:0] status_q;
  logic [7:0] status_d;
  csf_alu_type alu_q;
  csf_alu_type alu_d;
  logic [31:0] sym_q;
  logic [15:0] ea_q;
  logic legal_q;
  logic acc_q;
  logic fret_q;
  logic nret_q;
  logic aw_q;
  logic w_q;
  logic bv_q;
  logic [1:0] br_q;
  logic [11:0] awa_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;
  logic rv_q;
  logic [31:0] rd_q;
  logic [1:0] rr_q;
  logic chk_legal;
  logic [15:0] chk_target;

  wire is_add = exec.valid && exec.op == CSF_OP_ADD;
  wire is_sub = exec.valid && exec.op == CSF_OP_SUB;
  wire is_da = exec.valid && exec.op == CSF_OP_DA;
  wire is_fint = exec.valid && exec.op == CSF_OP_FAST_INT;
  wire is_interrupt_return_instruction = exec.valid && exec.op == CSF_OP_INTERRUPT_RETURN_INSTRUCTION;
  wire fast_on = status_q[CSF_FAST_BIT];
  wire [8:0] sum9 = {1'b0, exec.a} + {1'b0, exec.b};
  wire [8:0] dif9 = {1'b0, exec.a} - {1'b0, exec.b};
  // nibble carry out of bit 3
  wire half_add = ({1'b0, exec.a[3:0]} + {1'b0, exec.b[3:0]}) > 5'h0f;
  wire half_sub = exec.a[3:0] < exec.b[3:0];
  wire carry_in = alu_q.carry;
  wire lo_fix = status_q[CSF_HALF_BIT] || exec.a[3:0] > CSF_BCD_LO;
  wire hi_fix = carry_in || exec.a > CSF_BCD_HI;
  wire [7:0] adj = (lo_fix ? CSF_ADJ_LO : 8'h00)
    | (hi_fix ? CSF_ADJ_HI : 8'h00);
  // correction depends on half-carry and kind
  wire [7:0] da_res = status_q[CSF_DKIND_BIT] ? exec.a - adj
    : exec.a + adj;

  // axi write: collect address and data in any order
  wire wr_fire = aw_q && w_q && !bv_q;
  wire wr_status = awa_q == CSF_STATUS_ADDR;
  wire wr_sym = awa_q == CSF_SYM_ADDR;
  wire wr_hit = wr_status || wr_sym;
  wire rd_status = s_axi_araddr == CSF_STATUS_ADDR;
  wire rd_sym = s_axi_araddr == CSF_SYM_ADDR;
  wire rd_idx = s_axi_araddr == CSF_IDX_ADDR;
  wire rd_ea = s_axi_araddr == CSF_EA_ADDR;
  wire rd_hit = rd_status || rd_sym || rd_idx || rd_ea;
  wire [31:0] rd_mux = rd_status ? {24'h000000, status_q}
    : rd_sym ? sym_q
    : rd_idx ? {31'h0, legal_q}
    : rd_ea ? {16'h0000, ea_q} : 32'h00000000;
  wire rd_take = s_axi_arvalid && !rv_q;

  always_comb
  begin
    status_d = status_q;
    alu_d = alu_q;
    case (exec.valid ? exec.op : CSF_OP_NONE)
      CSF_OP_ADD:
      begin
        alu_d.result = sum9[7:0];
        alu_d.carry = sum9[8];
        status_d[CSF_HALF_BIT] = half_add;
        status_d[CSF_DKIND_BIT] = 1'b0;
      end
      CSF_OP_SUB:
      begin
        alu_d.result = dif9[7:0];
        alu_d.carry = dif9[8];
        status_d[CSF_HALF_BIT] = half_sub;
        status_d[CSF_DKIND_BIT] = 1'b1;
      end
      CSF_OP_DA:
      begin
        alu_d.result = da_res;
        alu_d.carry = hi_fix;
      end
      CSF_OP_SB0: status_d[CSF_BANK_BIT] = 1'b0;
      CSF_OP_SB1: status_d[CSF_BANK_BIT] = 1'b1;
      CSF_OP_FAST_INT: status_d[CSF_FAST_BIT] = 1'b1;
      CSF_OP_INTERRUPT_RETURN_INSTRUCTION: status_d[CSF_FAST_BIT] = 1'b0;
      default: status_d = status_q;
    endcase
    if (wr_fire && wr_status && ws_q[0])
    begin
      status_d = wd_q[7:0];
    end
  end

  // operand word: [2:0] mode, [3] working, [6:4] bit, [15:8] reg,
  // [31:16] field; base is the alu result over the exec b operand
  csf_operand_check csf_operand_check_i
  (
    .mode(csf_mode_type'(sym_q[2:0])),
    .reg_num(sym_q[15:8]),
    .working(sym_q[3]),
    .bit_idx(sym_q[6:4]),
    .base({alu_q.result, exec.b}),
    .field(sym_q[31:16]),
    .legal(chk_legal),
    .target(chk_target)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      status_q <= CSF_STATUS_RESET;
      alu_q <= '0;
      sym_q <= 32'h00000000;
      ea_q <= 16'h0000;
      legal_q <= 1'b0;
      acc_q <= 1'b0;
      fret_q <= 1'b0;
      nret_q <= 1'b0;
    end
    else if (ce)
    begin
      status_q <= status_d;
      alu_q <= alu_d;
      legal_q <= chk_legal;
      ea_q <= chk_target;
      // no interrupt while fast service runs
      acc_q <= int_request && !fast_on && !is_fint;
      fret_q <= is_interrupt_return_instruction && fast_on;
      nret_q <= is_interrupt_return_instruction && !fast_on;
      if (wr_fire && wr_sym)
      begin
        sym_q <= wd_q;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      bv_q <= 1'b0;
      br_q <= CSF_RESP_OKAY;
      awa_q <= 12'h000;
      wd_q <= 32'h00000000;
      ws_q <= 4'h0;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && !aw_q)
      begin
        aw_q <= 1'b1;
        awa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_q)
      begin
        w_q <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        bv_q <= 1'b1;
        br_q <= wr_hit ? CSF_RESP_OKAY : CSF_RESP_SLVERR;
      end
      if (bv_q && s_axi_bready)
      begin
        bv_q <= 1'b0;
        aw_q <= 1'b0;
        w_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rv_q <= 1'b0;
      rd_q <= 32'h00000000;
      rr_q <= CSF_RESP_OKAY;
    end
    else if (ce)
    begin
      if (rd_take)
      begin
        rv_q <= 1'b1;
        rd_q <= rd_mux;
        rr_q <= rd_hit ? CSF_RESP_OKAY : CSF_RESP_SLVERR;
      end
      else if (rv_q && s_axi_rready)
      begin
        rv_q <= 1'b0;
      end
    end
  end

  // ready for one cycle, the cycle after a channel is captured; slows bursts but
  // keeps every output a flop
  logic awr_q;
  logic wr_q;
  logic arr_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awr_q <= 1'b0;
      wr_q <= 1'b0;
      arr_q <= 1'b0;
    end
    else if (ce)
    begin
      awr_q <= !aw_q && !awr_q && s_axi_awvalid;
      wr_q <= !w_q && !wr_q && s_axi_wvalid;
      arr_q <= rd_take;
    end
  end

  assign s_axi_awready = awr_q;
  assign s_axi_wready = wr_q;
  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp = br_q;
  assign s_axi_arready = arr_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rdata = rd_q;
  assign s_axi_rresp = rr_q;
  assign alu_out = alu_q;
  assign bank_sel = status_q[CSF_BANK_BIT];
  assign int_accept = acc_q;
  assign fast_return = fret_q;
  assign normal_return = nret_q;
  assign operand_legal = legal_q;
  assign operand_target = ea_q;
endmodule : csf_status_flags

// [csf_status_flags_assertions.sv]
`timescale 1ns/1ns
module csf_status_flags_assertions
  import csf_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire csf_exec_type exec,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic bank_sel,
  input wire logic int_accept,
  input wire logic fast_return,
  input wire logic normal_return
);
  wire go = ce && exec.valid;
  wire fi = go && exec.op == CSF_OP_FAST_INT;
  wire rt = go && exec.op == CSF_OP_INTERRUPT_RETURN_INSTRUCTION;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  chk_bank_zero:
  assert property (go && exec.op == CSF_OP_SB0 |=> !bank_sel)
    else $error("bank not cleared");
  chk_bank_one:
  assert property (go && exec.op == CSF_OP_SB1 |=> bank_sel)
    else $error("bank not set");
  chk_int_blocked:
  assert property (fi |=> !int_accept [*2])
    else $error("interrupt not blocked");
  chk_fast_return:
  assert property (fi ##1 rt |=> fast_return && !normal_return)
    else $error("fast return missed");
  chk_return_once:
  assert property (rt |=> fast_return != normal_return)
    else $error("return kind wrong");
  chk_fast_cleared:
  assert property (rt ##1 rt |=> normal_return && !fast_return)
    else $error("fast bit kept");
  chk_write_hold:
  assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  chk_read_hold:
  assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped");
endmodule : csf_status_flags_assertions

bind csf_status_flags csf_status_flags_assertions csf_chk_i
(
  .aclk, .aresetn, .ce, .exec, .s_axi_bvalid, .s_axi_bready,
  .s_axi_rvalid, .s_axi_rready, .bank_sel, .int_accept,
  .fast_return, .normal_return
);

// [csf_status_flags_bench.sv]
`timescale 1ns/1ns
module csf_status_flags_bench
  import csf_pkg::*;
;
  logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1, int_request = 1'h0;
  csf_exec_type exec = '0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready;
  logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic bank_sel, int_accept, fast_return, normal_return, operand_legal;
  logic [15:0] operand_target;
  csf_alu_type alu_out;
  int error_cnt = 0, n_tests = 0, cyc = 0;
  // odd pair first; targets use base 4230 from the add of 12 and 30
  logic [31:0] ow [7] = '{32'h00000502, 32'h00000f09, 32'h00800003,
    32'h007f0004, 32'hfff00005, 32'hbeef0006, 32'h0000ff70};
  logic [15:0] et [7] = '{16'h0, 16'h0, 16'h41b0, 16'h42af, 16'h4220,
    16'hbeef, 16'h07ff};
  csf_status_flags csf_status_flags_i
  (
    .aclk, .aresetn, .ce, .exec, .int_request, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .alu_out,
    .bank_sel, .int_accept, .fast_return, .normal_return, .operand_legal,
    .operand_target
  );
  always #5 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      stop_test;
    end
  end
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test
  // valid is left for idle to drop, so ops can run back to back
  task op(input csf_op_type o, input logic [7:0] x, y);
    @(posedge aclk);
    exec <= '{1'h1, o, x, y};
  endtask : op
  task idle;
    @(posedge aclk);
    exec.valid <= 1'h0;
  endtask : idle
  task axi_wr(input logic [11:0] ad, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    while (s_axi_bvalid !== 1'h1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : axi_wr
  task axi_rd(input logic [11:0] ad);
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    while (s_axi_rvalid !== 1'h1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : axi_rd
  task arith(input logic s, input logic [7:0] x, y);
    logic [8:0] r;
    logic h;
    r = s ? x - y : x + y;
    h = s ? x[3:0] < y[3:0] : x[3:0] + y[3:0] > 5'hf;
    op(s ? CSF_OP_SUB : CSF_OP_ADD, x, y);
    idle;
    #1 check(alu_out, {r[7:0], r[8]});
    axi_rd(CSF_STATUS_ADDR);
    check(rd[CSF_HALF_BIT], h);
    check(rd[CSF_DKIND_BIT], s);
  endtask : arith
  // decimal value of two bcd bytes, wrapped to two digits
  function automatic logic [7:0] bcd_ref(input logic s,
    input logic [7:0] x, y);
    int a;
    int b;
    int v;
    a = x[7:4] * 10 + x[3:0];
    b = y[7:4] * 10 + y[3:0];
    v = s ? a - b + 100 : a + b;
    v = v % 100;
    return {4'(v / 10), 4'(v % 10)};
  endfunction : bcd_ref
  task bcd(input logic s, input logic [7:0] x, y);
    logic [8:0] r;
    r = s ? x - y : x + y;
    op(s ? CSF_OP_SUB : CSF_OP_ADD, x, y);
    op(CSF_OP_DA, r[7:0], 8'h00);
    idle;
    #1 check(alu_out.result, bcd_ref(s, x, y));
  endtask : bcd
  initial
  begin
    void'($urandom(7));
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    axi_rd(CSF_STATUS_ADDR);
    check(rd, 32'(CSF_STATUS_RESET));
    op(CSF_OP_SB1, 8'h0, 8'h0);
    idle;
    #1 check(bank_sel, 1'h1);
    op(CSF_OP_SB0, 8'h0, 8'h0);
    idle;
    #1 check(bank_sel, 1'h0);
    axi_wr(CSF_STATUS_ADDR, 32'h1);
    axi_rd(CSF_STATUS_ADDR);
    check({rs, rd[7:0], bank_sel}, {CSF_RESP_OKAY, 8'h01, 1'h1});
    axi_rd(12'hffc);
    check(rs, CSF_RESP_SLVERR);
    check(rd, 32'h0);
    // frozen core must ignore the bank instruction
    ce <= 1'h0;
    op(CSF_OP_SB0, 8'h0, 8'h0);
    idle;
    #1 check(bank_sel, 1'h1);
    @(posedge aclk);
    ce <= 1'h1;
    $display("bank test done");
    arith(1'h0, 8'h0f, 8'h01);
    arith(1'h1, 8'h10, 8'h01);
    repeat (16) arith(1'($urandom), 8'($urandom), 8'($urandom));
    $display("arith test done");
    bcd(1'h0, 8'h15, 8'h27);
    bcd(1'h1, 8'h15, 8'h42);
    bcd(1'h0, 8'h99, 8'h99);
    bcd(1'h1, 8'h00, 8'h01);
    repeat (16) bcd(1'($urandom), {4'($urandom % 10), 4'($urandom % 10)},
      {4'($urandom % 10), 4'($urandom % 10)});
    $display("bcd test done");
    int_request <= 1'h1;
    repeat (2) @(posedge aclk);
    #1 check(int_accept, 1'h1);
    op(CSF_OP_FAST_INT, 8'h0, 8'h0);
    idle;
    repeat (2) @(posedge aclk);
    #1 check(int_accept, 1'h0);
    axi_rd(CSF_STATUS_ADDR);
    check(rd[CSF_FAST_BIT], 1'h1);
    op(CSF_OP_INTERRUPT_RETURN_INSTRUCTION, 8'h0, 8'h0);
    idle;
    #1 check({fast_return, normal_return}, 2'h2);
    op(CSF_OP_INTERRUPT_RETURN_INSTRUCTION, 8'h0, 8'h0);
    idle;
    #1 check({fast_return, normal_return}, 2'h1);
    op(CSF_OP_FAST_INT, 8'h0, 8'h0);
    op(CSF_OP_INTERRUPT_RETURN_INSTRUCTION, 8'h0, 8'h0);
    op(CSF_OP_INTERRUPT_RETURN_INSTRUCTION, 8'h0, 8'h0);
    #1 check({fast_return, normal_return}, 2'h2);
    idle;
    #1 check({fast_return, normal_return}, 2'h1);
    $display("interrupt test done");
    op(CSF_OP_ADD, 8'h12, 8'h30);
    idle;
    for (int i = 0; i < 7; i++)
    begin
      axi_wr(CSF_SYM_ADDR, ow[i]);
      axi_rd(CSF_IDX_ADDR);
      check(rd[0], i != 0);
      axi_rd(CSF_EA_ADDR);
      if (i > 1) check(rd[15:0], et[i]);
    end
    $display("operand test done");
    stop_test;
  end
endmodule : csf_status_flags_bench
